// ---- verilog/fault_irq_pkg.sv ----
// Shared constants and types of the gate-drive fault interrupt block
package fault_irq_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_ENABLE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_LINES = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_RAW = 4'hc;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FLAGS_W = 10;
    localparam int ENABLE_W = 5;
    localparam int LINE_DESAT_POS = 0;
    localparam int LINE_VOLT_POS = 1;
    localparam int LINE_RUN_POS = 2;
    localparam int LINE_STOP_POS = 3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [FLAGS_W-1:0] FLAGS_RST = 10'h000;
    localparam logic [ENABLE_W-1:0] ENABLE_RST = 5'h00;

    // ----------------------------------------------------------------
    // Bus response codes
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    // Fault sources, same layout for raw levels and sticky flags
    typedef struct packed {
        logic [1:0] overcurrent_flags;
        logic link_overvolt_flag;
        logic low_supply_undervolt_flag;
        logic [2:0] low_side_desat_flags;
        logic [2:0] high_side_desat_flags;
    } fault_flags_t;

    // Local enables
    typedef struct packed {
        logic [1:0] overcurrent_irq_enables;
        logic link_overvolt_irq_enable;
        logic low_supply_undervolt_irq_enable;
        logic desat_irq_enable;
    } irq_enables_t;

    // Two request lines toward the CPU vector logic
    typedef struct packed {
        logic volt_req;
        logic desat_req;
    } irq_lines_t;

endpackage

// ---- verilog/level_sync2.sv ----
// Two-flop synchroniser for a bundle of asynchronous levels
module level_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// ---- verilog/gate_driver_interrupt_aggregator.sv ----
// Fault flag collection and two-line interrupt request for the gate-drive unit
//
// Summary of operation
// [R1] Requests reach the CPU only in run mode
// [R2] Stop entry or exit leaves flags untouched
// [R3] Exactly two request lines, one per vector
// [R4] Line 0: any desaturation flag with enable
// [R5] Line 1: undervoltage flag with its enable
// [R6] Line 1: link overvoltage flag with its enable
// [R7] Line 1: each overcurrent flag with own enable
// [R8] Lines are levels, held until flags cleared
module gate_driver_interrupt_aggregator (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // CPU mode, from logic on mclk
    input wire logic cpu_run_mode,
    input wire logic cpu_stop_mode,
    // Fault levels from the pre-driver and comparators
    input wire fault_irq_pkg::fault_flags_t raw_faults,
    // Interrupt requests
    output fault_irq_pkg::irq_lines_t irq_lines,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [fault_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [fault_irq_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [fault_irq_pkg::ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [fault_irq_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import fault_irq_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    fault_flags_t sync_faults;
    fault_flags_t flags_ff;
    fault_flags_t nxt_flags;
    fault_flags_t clr_mask;
    irq_enables_t enables_ff;
    irq_lines_t lines_ff;
    irq_lines_t nxt_lines;
    logic aw_got_ff;
    logic w_got_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic have_aw;
    logic have_w;
    logic do_write;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic [DATA_W-1:0] wr_bits;
    logic do_read;
    logic stop_dly_ff;

    // Byte-lane mask from write strobes
    function automatic logic [DATA_W-1:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Decode of a mapped word address
    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        is_mapped = (addr == OFS_FLAGS) || (addr == OFS_ENABLE) ||
                    (addr == OFS_LINES) || (addr == OFS_RAW);
    endfunction

    // ----------------------------------------------------------------
    // Fault input synchronisation
    // ----------------------------------------------------------------
    level_sync2 #(
        .WIDTH(FLAGS_W)
    ) u_fault_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(raw_faults),
        .sync_out(sync_faults)
    );

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign have_aw = aw_got_ff || (s_axi_awvalid && s_axi_awready);
    assign have_w = w_got_ff || (s_axi_wvalid && s_axi_wready);
    assign do_write = have_aw && have_w;
    assign wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
    assign wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
    assign wr_bits = wr_data & lane_mask(wr_strb);

    // Address and data may arrive in either order
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (do_write) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_got_ff <= 1'b1;
                    awaddr_ff <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_got_ff <= 1'b1;
                    wdata_ff <= s_axi_wdata;
                    wstrb_ff <= s_axi_wstrb;
                end
            end
        end
    end

    // Write response raised at the same edge that accepts the last of the two halves
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ----------------------------------------------------------------
    // Enable register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            enables_ff <= ENABLE_RST;
        end else if (do_write && wr_addr == OFS_ENABLE && wr_strb[0]) begin
            enables_ff <= wr_data[ENABLE_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Sticky fault flags
    // ----------------------------------------------------------------
    // Write one to clear; a fault present in the same cycle wins
    always_comb begin
        clr_mask = '0;
        if (do_write && wr_addr == OFS_FLAGS) begin
            clr_mask = wr_bits[FLAGS_W-1:0];
        end
        nxt_flags = (flags_ff & ~clr_mask) | sync_faults;
    end

    // Mode signals are not consulted here, so stop leaves flags alone
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_ff <= FLAGS_RST;
        end else begin
            flags_ff <= nxt_flags; // [R2] [R8]
        end
    end

    // ----------------------------------------------------------------
    // Request lines
    // ----------------------------------------------------------------
    always_comb begin
        nxt_lines.desat_req = cpu_run_mode && enables_ff.desat_irq_enable &&
            (|flags_ff.high_side_desat_flags ||
             |flags_ff.low_side_desat_flags); // [R1] [R4]
        nxt_lines.volt_req = cpu_run_mode && (
            (flags_ff.low_supply_undervolt_flag &&
             enables_ff.low_supply_undervolt_irq_enable) || // [R5]
            (flags_ff.link_overvolt_flag &&
             enables_ff.link_overvolt_irq_enable) || // [R6]
            |(flags_ff.overcurrent_flags &
              enables_ff.overcurrent_irq_enables)); // [R7] [R1]
    end

    // One flop per vector, each a level
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lines_ff <= '0;
        end else begin
            lines_ff <= nxt_lines; // [R3] [R8]
        end
    end

    assign irq_lines = lines_ff;

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !rvalid_ff;
    assign do_read = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (do_read) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= '0;
            case (s_axi_araddr)
                OFS_FLAGS: begin
                    rdata_ff[FLAGS_W-1:0] <= flags_ff;
                end
                OFS_ENABLE: begin
                    rdata_ff[ENABLE_W-1:0] <= enables_ff;
                end
                OFS_LINES: begin
                    rdata_ff[LINE_DESAT_POS] <= lines_ff.desat_req;
                    rdata_ff[LINE_VOLT_POS] <= lines_ff.volt_req;
                    rdata_ff[LINE_RUN_POS] <= cpu_run_mode;
                    rdata_ff[LINE_STOP_POS] <= cpu_stop_mode;
                end
                OFS_RAW: begin
                    rdata_ff[FLAGS_W-1:0] <= sync_faults;
                end
                default: begin
                    rresp_ff <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Helper: previous stop level for mode-change detection
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stop_dly_ff <= 1'b0;
        end else begin
            stop_dly_ff <= cpu_stop_mode;
        end
    end

    sequence s_mode_edge;
        cpu_stop_mode != stop_dly_ff;
    endsequence

    sequence s_quiet;
        sync_faults == '0 && clr_mask == '0;
    endsequence

    a_run_gates_lines: assert property ( // [R1]
        @(posedge mclk) disable iff (sys_rst)
        !cpu_run_mode |=> !irq_lines.desat_req && !irq_lines.volt_req)
        else $error("request raised outside run mode");

    a_stop_keeps_flags: assert property ( // [R2]
        @(posedge mclk) disable iff (sys_rst)
        s_mode_edge and s_quiet |=> flags_ff == $past(flags_ff))
        else $error("flags changed on stop entry or exit");

    a_desat_line_set: assert property ( // [R4]
        @(posedge mclk) disable iff (sys_rst)
        cpu_run_mode && enables_ff.desat_irq_enable &&
        (|flags_ff.high_side_desat_flags || |flags_ff.low_side_desat_flags)
        |=> irq_lines.desat_req)
        else $error("desaturation request missing");

    a_desat_line_clr: assert property ( // [R4]
        @(posedge mclk) disable iff (sys_rst)
        !enables_ff.desat_irq_enable |=> !irq_lines.desat_req)
        else $error("desaturation request while disabled");

    a_undervolt_line: assert property ( // [R5]
        @(posedge mclk) disable iff (sys_rst)
        cpu_run_mode && flags_ff.low_supply_undervolt_flag &&
        enables_ff.low_supply_undervolt_irq_enable |=> irq_lines.volt_req)
        else $error("undervoltage request missing");

    a_overvolt_line: assert property ( // [R6]
        @(posedge mclk) disable iff (sys_rst)
        cpu_run_mode && flags_ff.link_overvolt_flag &&
        enables_ff.link_overvolt_irq_enable |=> irq_lines.volt_req)
        else $error("link overvoltage request missing");

    a_overcurrent_line: assert property ( // [R7]
        @(posedge mclk) disable iff (sys_rst)
        cpu_run_mode && (flags_ff.overcurrent_flags[0] &&
        enables_ff.overcurrent_irq_enables[0] ||
        flags_ff.overcurrent_flags[1] &&
        enables_ff.overcurrent_irq_enables[1]) |=> irq_lines.volt_req)
        else $error("overcurrent request missing");

    a_volt_line_quiet: assert property ( // [R5] [R6] [R7]
        @(posedge mclk) disable iff (sys_rst)
        (flags_ff & {enables_ff.overcurrent_irq_enables,
         enables_ff.link_overvolt_irq_enable,
         enables_ff.low_supply_undervolt_irq_enable, 6'h00}) == '0
        |=> !irq_lines.volt_req)
        else $error("voltage request without enabled flag");

    a_fault_sticks: assert property ( // [R8]
        @(posedge mclk) disable iff (sys_rst)
        sync_faults.link_overvolt_flag |=>
        flags_ff.link_overvolt_flag ##1 irq_lines.volt_req ||
        !$past(cpu_run_mode) || !enables_ff.link_overvolt_irq_enable ||
        !cpu_run_mode || clr_mask != '0 || !$past(enables_ff[2]))
        else $error("fault flag not captured or lost");

    a_line_holds: assert property ( // [R8]
        @(posedge mclk) disable iff (sys_rst)
        irq_lines.desat_req && cpu_run_mode && $past(clr_mask) == '0 &&
        enables_ff.desat_irq_enable && !(do_write && wr_addr == OFS_ENABLE)
        |=> irq_lines.desat_req [*1])
        else $error("desaturation request dropped without clear");

    a_bresp_holds: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response withdrawn early");

endmodule

// ---- testbench/cpu_irq_model.sv ----
// CPU side model: sequences run and stop mode toward the fault interrupt block
module cpu_irq_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Mode request from the bench
    input wire logic want_stop,
    // Mode outputs
    output logic cpu_run_mode,
    output logic cpu_stop_mode
);
    timeunit 1ns;
    timeprecision 1ps;

    // Run drops before stop rises, and stop falls before run returns
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_run_mode <= 1'b1;
            cpu_stop_mode <= 1'b0;
        end else if (want_stop) begin
            cpu_stop_mode <= !cpu_run_mode;
            cpu_run_mode <= 1'b0;
        end else begin
            cpu_run_mode <= !cpu_stop_mode;
            cpu_stop_mode <= 1'b0;
        end
    end
endmodule

// ---- testbench/gate_driver_interrupt_aggregator_tb.sv ----
// Self-checking bench of the gate-drive fault interrupt block
module gate_driver_interrupt_aggregator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fault_irq_pkg::*;

    `define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
        $display("Error %s expected %h seen %h", nm, e, s); bad_count++; end end

    typedef struct packed {
        logic [31:0] d;
        logic [1:0] r;
        logic p;
    } note_t;

    logic mclk, sys_rst, want_stop, cpu_run_mode, cpu_stop_mode;
    fault_flags_t raw_faults;
    irq_lines_t irq_lines;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int bad_count = 0;
    int n_checks = 0;
    integer seed = 78378;
    note_t rq[$];
    logic [1:0] bq[$];
    logic [9:0] f;
    logic [4:0] en;

    cpu_irq_model cpu (.mclk(mclk), .sys_rst(sys_rst), .want_stop(want_stop),
        .cpu_run_mode(cpu_run_mode), .cpu_stop_mode(cpu_stop_mode));

    gate_driver_interrupt_aggregator DUT (.mclk(mclk), .sys_rst(sys_rst),
        .cpu_run_mode(cpu_run_mode), .cpu_stop_mode(cpu_stop_mode),
        .raw_faults(raw_faults), .irq_lines(irq_lines),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

    // ----------------------------------------------------------------
    // Clock, tasks
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    function automatic logic [1:0] exp_lines(input logic [9:0] fl, input logic [4:0] e);
        exp_lines[1] = (e[1] & fl[6]) | (e[2] & fl[7]) | (e[3] & fl[8]) | (e[4] & fl[9]);
        exp_lines[0] = e[0] & (|fl[5:0]);
    endfunction

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Waits for the answer; only the watchdog ends a hung wait
        forever begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        // Let an edge pass so a following call never reassigns bready at once
        @(posedge mclk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r,
                      input logic p);
        int k;
        rq.push_back('{d: d, r: r, p: p});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic results;
        $display("Checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Monitor: oldest note against each answer
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        note_t n;
        logic [1:0] b;
        if (s_axi_rvalid && s_axi_rready) begin
            n = rq.pop_front();
            `CHK("rdata", n.d, s_axi_rdata)
            `CHK("rresp", n.r, s_axi_rresp)
            if (n.p) begin
                `CHK("desat_req", n.d[0], irq_lines.desat_req)
                `CHK("volt_req", n.d[1], irq_lines.volt_req)
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            b = bq.pop_front();
            `CHK("bresp", b, s_axi_bresp)
        end
    end

    initial begin
        cycles(20000);
        bad_count++;
        results();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        want_stop = 1'b0;
        raw_faults = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        cycles(5);
        sys_rst <= 1'b0;
        @(posedge mclk);
        // Reset values, unmapped places, read-only bits
        rd(OFS_FLAGS, 32'h0, RESP_OKAY, 1'b0);
        rd(OFS_ENABLE, 32'h0, RESP_OKAY, 1'b0);
        rd(OFS_LINES, 32'h4, RESP_OKAY, 1'b1);
        rd(4'h2, 32'h0, RESP_SLVERR, 1'b0);
        wr(4'h6, 32'hffffffff, RESP_SLVERR);
        wr(OFS_ENABLE, 32'hffffffff, RESP_OKAY);
        rd(OFS_ENABLE, 32'h1f, RESP_OKAY, 1'b0);
        // Each source alone, with a short pulse that must stick
        for (int i = 0; i < 10; i++) begin
            f = 10'h1 << i;
            raw_faults <= fault_flags_t'(f);
            cycles(3);
            raw_faults <= '0;
            cycles(8);
            rd(OFS_FLAGS, {22'h0, f}, RESP_OKAY, 1'b0);
            rd(OFS_LINES, {28'h0, 2'b01, exp_lines(f, 5'h1f)}, RESP_OKAY, 1'b1);
            wr(OFS_FLAGS, {22'h0, f}, RESP_OKAY);
            cycles(4);
            rd(OFS_LINES, 32'h4, RESP_OKAY, 1'b1);
        end
        // Random sources against random enables
        for (int i = 0; i < 12; i++) begin
            f = 10'($random(seed));
            en = 5'($random(seed));
            wr(OFS_ENABLE, {27'h0, en}, RESP_OKAY);
            raw_faults <= fault_flags_t'(f);
            cycles(8);
            rd(OFS_FLAGS, {22'h0, f}, RESP_OKAY, 1'b0);
            rd(OFS_RAW, {22'h0, f}, RESP_OKAY, 1'b0);
            rd(OFS_LINES, {28'h0, 2'b01, exp_lines(f, en)}, RESP_OKAY, 1'b1);
            raw_faults <= '0;
            cycles(3);
            wr(OFS_FLAGS, 32'h3ff, RESP_OKAY);
            cycles(4);
            rd(OFS_FLAGS, 32'h0, RESP_OKAY, 1'b0);
        end
        // Stop mode: no requests, flags kept
        wr(OFS_ENABLE, 32'h1f, RESP_OKAY);
        // Lane 0 strobe low: enable register must not change
        s_axi_wstrb <= 4'he;
        wr(OFS_ENABLE, 32'h0, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(OFS_ENABLE, 32'h1f, RESP_OKAY, 1'b0);
        raw_faults <= fault_flags_t'(10'h081);
        cycles(3);
        raw_faults <= '0;
        cycles(8);
        rd(OFS_LINES, 32'h7, RESP_OKAY, 1'b1);
        want_stop <= 1'b1;
        cycles(6);
        rd(OFS_LINES, 32'h8, RESP_OKAY, 1'b1);
        rd(OFS_FLAGS, 32'h081, RESP_OKAY, 1'b0);
        want_stop <= 1'b0;
        cycles(6);
        rd(OFS_LINES, 32'h7, RESP_OKAY, 1'b1);
        rd(OFS_FLAGS, 32'h081, RESP_OKAY, 1'b0);
        cycles(4);
        results();
    end
endmodule
